//--- spsw_pkg.sv
// Purpose: shared constants for the speed/position switching axis sequencer
// Assumes: single controller clock, register word index on a 4-bit address
// Notes:   error codes are decimal 209 and 210 written in hex
package spsw_pkg;
	// ------------------------------------------------------------
	// register word indices
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_SPEED     = 4'h1;
	localparam logic [3:0] REG_TRAVEL    = 4'h2;
	localparam logic [3:0] REG_STATUS    = 4'h3;
	localparam logic [3:0] REG_FEED      = 4'h4;
	localparam logic [3:0] REG_POSTDOG   = 4'h5;
	localparam logic [3:0] REG_ERR       = 4'h6;
	localparam logic [3:0] REG_STROKE_LO = 4'h7;
	localparam logic [3:0] REG_STROKE_HI = 4'h8;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CB_FWD    = 0;
	localparam int CB_REV    = 1;
	localparam int CB_RESUME = 2;
	localparam int CB_STOP   = 3;
	localparam int CB_SWEN   = 4;
	localparam int CB_KEEP   = 5;
	localparam int CB_SRC    = 6;
	localparam int CB_NC     = 8;
	localparam int CB_BITDEV = 9;

	localparam logic [1:0] SRC_MODULE = 2'h0;
	localparam logic [1:0] SRC_DOG    = 2'h1;
	localparam logic [1:0] SRC_DI     = 2'h2;
	localparam logic [1:0] SRC_BIT    = 2'h3;

	// ------------------------------------------------------------
	// codes and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_OVERRUN   = 16'h00D1;
	localparam logic [15:0] ERR_STROKE    = 16'h00D2;
	localparam logic [15:0] RST_SPEED     = 16'h0000;
	localparam logic [31:0] RST_TRAVEL    = 32'h0000_0000;
	localparam logic [31:0] RST_STROKE_LO = 32'h8000_0000;
	localparam logic [31:0] RST_STROKE_HI = 32'h7FFF_FFFF;

	localparam logic [1:0] PH_NONE = 2'h0;
	localparam logic [1:0] PH_SPD  = 2'h1;
	localparam logic [1:0] PH_POS  = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SPEED = 2'b01,
		ST_POS   = 2'b10,
		ST_STOP  = 2'b11
	} spsw_state_e;
endpackage : spsw_pkg

//--- spsw_trig.sv
// Purpose: synchronise one trigger pin and apply its contact polarity
// Assumes: pin is asynchronous to CLK_I
// Notes:   output is a level, two cycles behind the pin
`timescale 1ns/100ps
module spsw_trig (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	input  wire logic nc_i,
	output logic      asserted_o
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			sync_r <= meta_r;
		end
	end

	// normally-closed contact asserts on the low level
	assign asserted_o = sync_r ^ nc_i;
endmodule : spsw_trig

//--- spsw_axis.sv
// Purpose: speed-to-position switching sequencer for one axis
// Assumes: one step of speed per clock, feed value moves by speed each clock
// Notes:   registers on a plain strobe port, read data one cycle later
// Notes on behaviour
// - trigger asserts on active level if normally-open, inactive if normally-closed
// - trigger source selectable: input module, amplifier dog, digital input, bit device
// - keep command off at start clears feed to 0, then accumulates all travel
// - keep command on at start preserves feed and updates it from start
// - travel change register is latched as travel when trigger switches
// - distance since switching to position mode goes to post-dog register
// - switch needs start accepted, speed phase running and switch enable on
// - enable and trigger on at start gives position only, no speed flag
// - travel below deceleration distance starts deceleration at the trigger
// - overrun sets error flag and stores code 209
// - overrun stop leaves positioning done flag off
// - no stroke check in speed phase; out of range at switch gives 210 and stop
// - resume accepted only after stop command in speed or position phase
// - resume from speed-phase stop restarts speed control awaiting trigger
// - resume from position-phase stop travels remaining distance to target
// - resume uses speed captured at original start, not later changes
// - forward start moves address up, reverse start moves address down
// - trigger already on before enable turned on is ignored
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module spsw_axis
	import spsw_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RESET_I,
	input  wire logic [3:0]  ADDR_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [31:0] RDATA_O,
	input  wire logic        TRIG_MODULE_I,
	input  wire logic        TRIG_DOG_I,
	input  wire logic        TRIG_DI_I,
	output logic      [31:0] FEED_O,
	output logic      [15:0] SPEED_O,
	output logic             DIR_O,
	output logic             START_ACC_O,
	output logic             SPEED_PHASE_O,
	output logic             POS_DONE_O,
	output logic             ERR_O
);
	// ------------------------------------------------------------
	// registers and decode
	// ------------------------------------------------------------
	spsw_state_e        state_r, state_nxt;
	logic               swen_r, keep_r, nc_r, bitdev_r;
	logic        [1:0]  src_r;
	logic        [15:0] cmd_speed_r, run_speed_r, start_speed_r, speed_r, spd_nxt, step;
	logic        [31:0] travel_chg_r, travel_r, postdog_r, stroke_lo_r, stroke_hi_r;
	logic        [31:0] remaining, dd, rdata_r, rmux;
	logic signed [31:0] feed_r, base, tgt;
	logic               dir_r, dir_now, start_acc_r, done_r, err_r, pos_phase_r;
	logic        [15:0] err_code_r;
	logic        [1:0]  stop_phase_r;
	logic               trig_prev_r, trig_lvl, trig_mod, trig_dog, trig_di;
	logic               wr_ctrl, cmd_fwd, cmd_rev, cmd_resume, cmd_stop;
	logic               start, resume, stop, sw_evt, direct_pos, enter_pos;
	logic               stroke_bad, overrun, pos_finish, trig_rise;

	assign wr_ctrl    = WR_I && (ADDR_I == REG_CTRL);
	assign cmd_fwd    = wr_ctrl && WDATA_I[CB_FWD];
	assign cmd_rev    = wr_ctrl && WDATA_I[CB_REV] && !WDATA_I[CB_FWD];
	assign cmd_resume = wr_ctrl && WDATA_I[CB_RESUME];
	assign cmd_stop   = wr_ctrl && WDATA_I[CB_STOP];

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			swen_r       <= 1'b0;
			keep_r       <= 1'b0;
			src_r        <= SRC_MODULE;
			nc_r         <= 1'b0;
			bitdev_r     <= 1'b0;
			cmd_speed_r  <= RST_SPEED;
			travel_chg_r <= RST_TRAVEL;
			stroke_lo_r  <= RST_STROKE_LO;
			stroke_hi_r  <= RST_STROKE_HI;
		end else if (WR_I) begin
			unique case (ADDR_I)
				REG_CTRL: begin
					swen_r   <= WDATA_I[CB_SWEN];
					keep_r   <= WDATA_I[CB_KEEP];
					src_r    <= WDATA_I[CB_SRC +: 2];
					nc_r     <= WDATA_I[CB_NC];
					bitdev_r <= WDATA_I[CB_BITDEV];
				end
				REG_SPEED:     cmd_speed_r  <= WDATA_I[15:0];
				REG_TRAVEL:    travel_chg_r <= WDATA_I;
				REG_STROKE_LO: stroke_lo_r  <= WDATA_I;
				REG_STROKE_HI: stroke_hi_r  <= WDATA_I;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// trigger sources
	// ------------------------------------------------------------
	spsw_trig u_trig_mod (.clk_i(CLK_I), .rst_i(RESET_I), .pin_i(TRIG_MODULE_I),
		.nc_i(nc_r), .asserted_o(trig_mod));
	spsw_trig u_trig_dog (.clk_i(CLK_I), .rst_i(RESET_I), .pin_i(TRIG_DOG_I),
		.nc_i(nc_r), .asserted_o(trig_dog));
	spsw_trig u_trig_di  (.clk_i(CLK_I), .rst_i(RESET_I), .pin_i(TRIG_DI_I),
		.nc_i(nc_r), .asserted_o(trig_di));

	always_comb begin
		unique case (src_r)
			SRC_MODULE: trig_lvl = trig_mod;
			SRC_DOG:    trig_lvl = trig_dog;
			SRC_DI:     trig_lvl = trig_di;
			SRC_BIT:    trig_lvl = bitdev_r ^ nc_r;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			trig_prev_r <= 1'b0;
		else
			trig_prev_r <= trig_lvl;
	end
	assign trig_rise = trig_lvl && !trig_prev_r;

	// ------------------------------------------------------------
	// sequencing decisions
	// ------------------------------------------------------------
	assign start  = (cmd_fwd || cmd_rev) && (state_r == ST_IDLE);
	assign resume = cmd_resume && (state_r == ST_IDLE) && (stop_phase_r != PH_NONE);
	assign stop   = cmd_stop && ((state_r == ST_SPEED) || (state_r == ST_POS));
	// only a fresh edge seen while enable is on may switch
	assign sw_evt = (state_r == ST_SPEED) && trig_rise && swen_r && start_acc_r && !stop;
	assign direct_pos = start && WDATA_I[CB_SWEN] && trig_lvl;
	assign enter_pos  = sw_evt || direct_pos;

	assign dir_now = direct_pos ? cmd_rev : dir_r;
	assign base    = (direct_pos && !WDATA_I[CB_KEEP]) ? 32'sh0000_0000 : feed_r;
	assign tgt     = dir_now ? base - $signed(travel_chg_r) : base + $signed(travel_chg_r);
	assign stroke_bad = enter_pos && ((tgt > $signed(stroke_hi_r)) || (tgt < $signed(stroke_lo_r)));
	// distance to stop from current speed, one unit of speed shed per clock
	assign dd      = ({16'h0000, speed_r} * {16'h0000, speed_r - 16'h0001}) >> 1;
	assign overrun = sw_evt && !stroke_bad && (travel_chg_r < dd);

	assign remaining = travel_r - postdog_r;

	always_comb begin
		spd_nxt = 16'h0000;
		step    = 16'h0000;
		unique case (state_r)
			ST_IDLE: ;
			ST_SPEED: begin
				if (speed_r < run_speed_r)
					spd_nxt = speed_r + 16'h0001;
				else if (speed_r > run_speed_r)
					spd_nxt = speed_r - 16'h0001;
				else
					spd_nxt = speed_r;
				step = spd_nxt;
			end
			ST_POS: begin
				// hold at least one unit so the last bit of travel is covered
				if (remaining <= dd + {16'h0000, speed_r})
					spd_nxt = (speed_r > 16'h0001) ? speed_r - 16'h0001 : 16'h0001;
				else if (speed_r < run_speed_r)
					spd_nxt = speed_r + 16'h0001;
				else
					spd_nxt = run_speed_r;
				// clamp lands exactly on the target
				step = (remaining < {16'h0000, spd_nxt}) ? remaining[15:0] : spd_nxt;
			end
			ST_STOP: begin
				spd_nxt = (speed_r != 16'h0000) ? speed_r - 16'h0001 : 16'h0000;
				step    = spd_nxt;
			end
		endcase
	end

	assign pos_finish = (state_r == ST_POS) && !stop && (remaining == {16'h0000, step});

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start)
					state_nxt = direct_pos ? (stroke_bad ? ST_STOP : ST_POS) : ST_SPEED;
				else if (resume)
					state_nxt = (stop_phase_r == PH_POS) ? ST_POS : ST_SPEED;
			end
			ST_SPEED: begin
				if (stop || stroke_bad || overrun)
					state_nxt = ST_STOP;
				else if (sw_evt)
					state_nxt = ST_POS;
			end
			ST_POS: begin
				if (stop)
					state_nxt = ST_STOP;
				else if (pos_finish)
					state_nxt = ST_IDLE;
			end
			ST_STOP: begin
				if (speed_r == 16'h0000)
					state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------
	// motion: speed, direction, feed and post-switch travel
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			speed_r       <= 16'h0000;
			run_speed_r   <= 16'h0000;
			start_speed_r <= 16'h0000;
			dir_r         <= 1'b0;
		end else begin
			speed_r <= (pos_finish || state_nxt == ST_IDLE) ? 16'h0000 : spd_nxt;
			if (start) begin
				start_speed_r <= cmd_speed_r;
				run_speed_r   <= cmd_speed_r;
				dir_r         <= cmd_rev;
			end else if (resume)
				run_speed_r <= start_speed_r;
			else if (WR_I && ADDR_I == REG_SPEED && state_r != ST_IDLE)
				run_speed_r <= WDATA_I[15:0];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I)
			feed_r <= 32'sh0000_0000;
		else if (start && !WDATA_I[CB_KEEP])
			feed_r <= 32'sh0000_0000;
		else if (dir_r)
			feed_r <= feed_r - $signed({16'h0000, step});
		else
			feed_r <= feed_r + $signed({16'h0000, step});
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			travel_r    <= RST_TRAVEL;
			postdog_r   <= 32'h0000_0000;
			pos_phase_r <= 1'b0;
		end else if (enter_pos) begin
			travel_r    <= travel_chg_r;
			postdog_r   <= 32'h0000_0000;
			pos_phase_r <= 1'b1;
		end else if (start || (resume && stop_phase_r == PH_SPD)) begin
			pos_phase_r <= 1'b0;
		end else if (pos_phase_r && state_r != ST_IDLE) begin
			postdog_r <= postdog_r + {16'h0000, step};
		end
	end

	// ------------------------------------------------------------
	// flags and error
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			start_acc_r  <= 1'b0;
			done_r       <= 1'b0;
			stop_phase_r <= PH_NONE;
		end else begin
			start_acc_r <= (state_nxt != ST_IDLE);
			if (start || resume)
				done_r <= 1'b0;
			else if (pos_finish)
				done_r <= 1'b1;
			if (start || resume)
				stop_phase_r <= PH_NONE;
			else if (stop)
				stop_phase_r <= pos_phase_r ? PH_POS : PH_SPD;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			err_r      <= 1'b0;
			err_code_r <= ERR_NONE;
		end else if (overrun) begin
			err_r      <= 1'b1;
			err_code_r <= ERR_OVERRUN;
		end else if (stroke_bad) begin
			err_r      <= 1'b1;
			err_code_r <= ERR_STROKE;
		end else if (WR_I && ADDR_I == REG_ERR) begin
			err_r      <= 1'b0;
			err_code_r <= ERR_NONE;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		unique case (ADDR_I)
			REG_CTRL:      rmux = {22'h000000, bitdev_r, nc_r, src_r, keep_r, swen_r, 4'h0};
			REG_SPEED:     rmux = {16'h0000, cmd_speed_r};
			REG_TRAVEL:    rmux = travel_chg_r;
			REG_STATUS:    rmux = {22'h000000, state_r, dir_r, stop_phase_r, err_r,
				done_r, pos_phase_r, SPEED_PHASE_O, start_acc_r};
			REG_FEED:      rmux = feed_r;
			REG_POSTDOG:   rmux = postdog_r;
			REG_ERR:       rmux = {16'h0000, err_code_r};
			REG_STROKE_LO: rmux = stroke_lo_r;
			REG_STROKE_HI: rmux = stroke_hi_r;
			default:       rmux = 32'h0000_0000;
		endcase
	end

	logic spd_flag_r;
	always_ff @(posedge CLK_I) begin
		if (RESET_I) begin
			rdata_r    <= 32'h0000_0000;
			spd_flag_r <= 1'b0;
		end else begin
			rdata_r    <= RD_I ? rmux : 32'h0000_0000;
			spd_flag_r <= (state_nxt == ST_SPEED);
		end
	end

	assign RDATA_O       = rdata_r;
	assign FEED_O        = feed_r;
	assign SPEED_O       = speed_r;
	assign DIR_O         = dir_r;
	assign START_ACC_O   = start_acc_r;
	assign SPEED_PHASE_O = spd_flag_r;
	assign POS_DONE_O    = done_r;
	assign ERR_O         = err_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	sequence s_switch;
		(state_r == ST_SPEED) ##1 (state_r == ST_POS);
	endsequence
	sequence s_overrun;
		overrun ##1 (state_r == ST_STOP);
	endsequence

	a_switch_gate: assert property (s_switch |-> $past(swen_r) && $past(trig_rise))
		else $error("switch without enable or fresh trigger");
	a_direct_pos: assert property (direct_pos && !stroke_bad |=> state_r == ST_POS && !SPEED_PHASE_O)
		else $error("direct position start wrong");
	a_feed_clear: assert property (start && !WDATA_I[CB_KEEP] |=> feed_r == 32'sh0000_0000)
		else $error("feed not cleared at start");
	a_feed_keep: assert property (start && WDATA_I[CB_KEEP] |=> feed_r == $past(feed_r))
		else $error("feed not kept at start");
	a_travel_latch: assert property (sw_evt |=> travel_r == $past(travel_chg_r) && postdog_r == 0)
		else $error("travel not latched at switch");
	a_overrun_code: assert property (s_overrun |-> err_r && err_code_r == ERR_OVERRUN)
		else $error("overrun code missing");
	a_overrun_nodone: assert property (overrun |=> (!done_r)[*8])
		else $error("done set after overrun");
	a_stroke_err: assert property (stroke_bad |=> err_code_r == ERR_STROKE && state_r == ST_STOP)
		else $error("stroke error missing");
	a_resume_gate: assert property (cmd_resume && stop_phase_r == PH_NONE && state_r == ST_IDLE
		|=> state_r == ST_IDLE)
		else $error("resume accepted without stop");
	a_resume_speed: assert property (resume |=> run_speed_r == $past(start_speed_r))
		else $error("resume speed not original");
	a_done_target: assert property ($rose(done_r) |-> postdog_r == travel_r && speed_r == 0)
		else $error("done away from target");
	a_dir_start: assert property (start |=> DIR_O == $past(cmd_rev))
		else $error("direction wrong at start");
endmodule : spsw_axis

//--- spsw_far.sv
// Purpose: far-side model of the three trigger pins of one axis
// Assumes: only the selected source carries the switch trigger
// Notes:   unselected pins toggle every cycle so a wrong source pick shows up
`timescale 1ns/100ps
module spsw_far
	import spsw_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       asserted_i,
	input  wire logic [1:0] src_i,
	input  wire logic       nc_i,
	output logic            trig_module_o,
	output logic            trig_dog_o,
	output logic            trig_di_o
);
	logic pin_lvl;
	logic tog_r;

	// a closed contact opens to signal the trigger
	assign pin_lvl = asserted_i ^ nc_i;

	initial begin
		tog_r = 1'b0;
		trig_module_o = 1'b0;
		trig_dog_o = 1'b0;
		trig_di_o = 1'b0;
	end

	always @(posedge clk_i) begin
		tog_r         <= ~tog_r;
		trig_module_o <= (src_i == SRC_MODULE) ? pin_lvl : tog_r;
		trig_dog_o    <= (src_i == SRC_DOG) ? pin_lvl : tog_r;
		trig_di_o     <= (src_i == SRC_DI) ? pin_lvl : tog_r;
	end
endmodule : spsw_far

//--- tb_speed_position_switch_axis.sv
// Purpose: self-checking bench for the speed/position switching axis
// Assumes: accel and decel of one speed unit per clock
// Notes:   position-only starts give exact feed values to compare against
`timescale 1ns/100ps
module tb_speed_position_switch_axis
	import spsw_pkg::*;
;
	logic        clk, rst, wr, rd, trg_m, trg_d, trg_i;
	logic        dir, sacc, sph, done, err, asserted, nc, spd_seen;
	logic [3:0]  addr;
	logic [1:0]  src;
	logic [31:0] wdata, rdata, feed, d, c;
	logic [15:0] spd, max_spd;
	int          bad_count, compares;

	spsw_axis i_dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .TRIG_MODULE_I(trg_m), .TRIG_DOG_I(trg_d),
		.TRIG_DI_I(trg_i), .FEED_O(feed), .SPEED_O(spd), .DIR_O(dir), .START_ACC_O(sacc),
		.SPEED_PHASE_O(sph), .POS_DONE_O(done), .ERR_O(err));
	spsw_far i_far (.clk_i(clk), .asserted_i(asserted), .src_i(src), .nc_i(nc),
		.trig_module_o(trg_m), .trig_dog_o(trg_d), .trig_di_o(trg_i));

	// ------------------------------------------------------------
	// clock, monitors, watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// history restarts with each start or resume written on the bus
	always @(posedge clk) begin
		if (rst || (wr && addr == REG_CTRL && |wdata[CB_RESUME:CB_FWD])) begin
			spd_seen <= 1'b0;
			max_spd  <= 16'h0;
		end else begin
			if (sph === 1'b1) spd_seen <= 1'b1;
			if (spd > max_spd) max_spd <= spd;
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wrr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wrr
	task automatic rdr(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		v = rdata;
	endtask : rdr
	task automatic go(input int b);
		wrr(REG_CTRL, c | (32'h1 << b));
	endtask : go
	// waits for the axis to halt; mode 1 also needs start accepted low
	task automatic wait_halt(input bit idle);
		int n;
		n = 0;
		tick(2);
		while (!(spd === 16'h0 && (!idle || sacc === 1'b0)) && n < 3000) begin
			tick(1);
			n++;
		end
		chk("halt wait", 32'h0, (n >= 3000) ? 32'h1 : 32'h0);
		tick(2);
	endtask : wait_halt
	function automatic logic [31:0] ctl(logic en, logic kp, logic [1:0] s, logic n, logic b);
		ctl = 32'h0;
		ctl[CB_SWEN] = en;
		ctl[CB_KEEP] = kp;
		ctl[CB_SRC +: 2] = s;
		ctl[CB_NC] = n;
		ctl[CB_BITDEV] = b;
	endfunction : ctl

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		asserted = 1'b0;
		src = SRC_MODULE;
		nc = 1'b0;
		bad_count = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdr(REG_STROKE_LO, d);
		chk("stroke lo", RST_STROKE_LO, d);
		rdr(REG_ERR, d);
		chk("err code", {16'h0, ERR_NONE}, d);
		rdr(4'hF, d);
		chk("unmapped", 32'h0, d);
		$display("test reset done");
		// switch during speed phase with a changed travel value
		c = ctl(1, 0, SRC_MODULE, 0, 0);
		wrr(REG_SPEED, 32'h8);
		wrr(REG_TRAVEL, 32'h32);
		go(CB_FWD);
		tick(20);
		chk("speed phase", 32'h1, {31'h0, sph});
		chk("speed", 32'h8, {16'h0, spd});
		wrr(REG_TRAVEL, 32'h78);
		asserted <= 1'b1;
		wait_halt(1);
		chk("done", 32'h1, {31'h0, done});
		chk("dir fwd", 32'h0, {31'h0, dir});
		rdr(REG_POSTDOG, d);
		chk("postdog", 32'h78, d);
		go(CB_RESUME);
		tick(3);
		chk("refused resume", 32'h0, {31'h0, sacc});
		$display("test switch done");
		// trigger already on at start: position only
		wrr(REG_TRAVEL, 32'h28);
		go(CB_FWD);
		wait_halt(1);
		chk("no speed flag", 32'h0, {31'h0, spd_seen});
		chk("feed cleared", 32'h28, feed);
		// keep command held on for the whole run, reverse direction
		c = ctl(1, 1, SRC_MODULE, 0, 0);
		wrr(REG_TRAVEL, 32'h1E);
		go(CB_REV);
		wait_halt(1);
		chk("feed kept", 32'hA, feed);
		chk("dir rev", 32'h1, {31'h0, dir});
		$display("test feed done");
		for (int s = 0; s < 4; s++) begin
			src <= s[1:0];
			nc <= (s == 1 || s == 2);
			c = ctl(1, 0, s[1:0], (s == 1 || s == 2), (s == 3));
			wrr(REG_CTRL, c);
			tick(6);
			go(CB_FWD);
			wait_halt(1);
			chk("source feed", 32'h1E, feed);
		end
		$display("test sources done");
		// enable after trigger, speed change, stop and resume in speed phase
		src <= SRC_MODULE;
		nc <= 1'b0;
		asserted <= 1'b0;
		c = ctl(0, 0, SRC_MODULE, 0, 0);
		go(CB_FWD);
		tick(10);
		asserted <= 1'b1;
		tick(6);
		c = ctl(1, 0, SRC_MODULE, 0, 0);
		wrr(REG_CTRL, c);
		tick(20);
		chk("late enable", 32'h1, {31'h0, sph});
		wrr(REG_SPEED, 32'h4);
		tick(12);
		chk("changed speed", 32'h4, {16'h0, spd});
		go(CB_STOP);
		wait_halt(0);
		rdr(REG_STATUS, d);
		chk("stop phase spd", {30'h0, PH_SPD}, {30'h0, d[6:5]});
		go(CB_RESUME);
		tick(20);
		chk("resumed speed", 32'h1, {31'h0, sph});
		chk("start speed", 32'h8, {16'h0, max_spd});
		asserted <= 1'b0;
		wrr(REG_TRAVEL, 32'h28);
		tick(6);
		asserted <= 1'b1;
		wait_halt(1);
		chk("resume done", 32'h1, {31'h0, done});
		rdr(REG_POSTDOG, d);
		chk("resume postdog", 32'h28, d);
		// stop in position phase, resume the remaining distance
		wrr(REG_TRAVEL, 32'hC8);
		go(CB_FWD);
		tick(15);
		go(CB_STOP);
		wait_halt(0);
		rdr(REG_STATUS, d);
		chk("stop phase pos", {30'h0, PH_POS}, {30'h0, d[6:5]});
		go(CB_RESUME);
		wait_halt(1);
		chk("remaining feed", 32'hC8, feed);
		$display("test resume done");
		// overrun: travel below deceleration distance
		asserted <= 1'b0;
		wrr(REG_TRAVEL, 32'h5);
		wrr(REG_SPEED, 32'h8);
		go(CB_FWD);
		tick(20);
		asserted <= 1'b1;
		tick(8);
		chk("early decel", 32'h4, {16'h0, spd});
		wait_halt(1);
		chk("err flag", 32'h1, {31'h0, err});
		chk("no done", 32'h0, {31'h0, done});
		rdr(REG_ERR, d);
		chk("overrun code", {16'h0, ERR_OVERRUN}, d);
		wrr(REG_ERR, 32'h0);
		tick(2);
		chk("err cleared", 32'h0, {31'h0, err});
		// target beyond the stroke range at a position-only start
		wrr(REG_STROKE_HI, 32'h14);
		wrr(REG_TRAVEL, 32'h64);
		go(CB_FWD);
		wait_halt(1);
		rdr(REG_ERR, d);
		chk("stroke code", {16'h0, ERR_STROKE}, d);
		chk("stroke no done", 32'h0, {31'h0, done});
		$display("test errors done");
		test_done();
	end
endmodule : tb_speed_position_switch_axis
